// ---- rtl/sdadc_ctrl.sv ----
// sigma-delta converter control: power, reference, mux, decimation
`timescale 1ns/1ns
module sdadc_ctrl #(
	parameter int PINS = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic internal_ref_enable,
	input wire logic ref_output_buffer_enable,
	input wire sdadc_pkg::sdadc_inctl_s input_control_reg,
	input wire logic [PINS-1:0] pin_analog_enable,
	input wire logic conversion_start,
	input wire logic single_conversion_select,
	input wire logic [10:0] osr_select,
	input wire logic mod_bit,
	input wire logic mod_bit_valid,
	input wire logic result_read,
	input wire logic flag_clear,
	output logic conv_power_on,
	output logic ref_gen_on,
	output logic ref_pin_drive,
	output logic ext_ref_accept,
	output logic [2:0] active_pair,
	output logic [2:0] active_gain,
	output logic [3:0] buffer_enable,
	output logic [PINS-1:0] pin_digital_disable,
	output logic [15:0] conversion_result_reg,
	output logic conversion_done_flag,
	output logic conversion_irq,
	output logic result_settling,
	output logic conversion_busy
);
	import sdadc_pkg::*;
	sdadc_state_e state_reg, state_next;
	logic [SDADC_ACC_W-1:0] acc_reg, acc_next;
	logic [10:0] cnt_reg, cnt_next;
	logic [2:0] pair_reg, pair_next, gain_reg, gain_next;
	logic [1:0] settle_reg, settle_next;
	logic [2:0] nconv_reg, nconv_next;
	logic [15:0] res_reg, res_next;
	logic flag_reg, flag_next, irq_reg, irq_next;
	logic [3:0] buf_reg, buf_next;
	logic [PINS-1:0] dis_reg, dis_next;
	logic pwr_reg, rgen_reg, rpin_reg, ext_reg;
	logic pwr_next, rgen_next, rpin_next, ext_next;
	logic busy_reg, busy_next, settling_reg, settling_next;
	logic rearm_reg, rearm_next;
	logic [10:0] osr_eff;
	logic step;
	logic [2:0] gain_req;
	always_comb begin
		osr_eff = (osr_select == 11'h000 || osr_select > 11'h400) ? 11'h400 : osr_select; // [RL14]
		gain_req = (input_control_reg.amp_gain_select > SDADC_GAIN_MAX) ? SDADC_GAIN_MAX
			: input_control_reg.amp_gain_select; // [RL7]
		step = (state_reg == SDADC_CONV) && conversion_start && mod_bit_valid
			&& (cnt_reg == osr_eff - 11'h001);
		state_next = state_reg;
		acc_next = acc_reg;
		cnt_next = cnt_reg;
		pair_next = pair_reg;
		gain_next = gain_reg;
		settle_next = settle_reg;
		nconv_next = nconv_reg;
		res_next = res_reg;
		irq_next = 1'b0;
		flag_next = flag_reg;
		rearm_next = rearm_reg;
		// single mode stays idle until start drops
		if (!conversion_start) begin
			rearm_next = 1'b0; // [RL16]
		end
		if (result_read || flag_clear) begin
			flag_next = 1'b0; // [RL15]
		end
		case (state_reg)
			SDADC_IDLE: begin
				acc_next = '0;
				cnt_next = '0;
				if (conversion_start && !rearm_reg) begin
					state_next = SDADC_CONV; // [RL1]
					nconv_next = SDADC_CNT_RST;
					pair_next = input_control_reg.input_pair_select; // [RL6]
					gain_next = gain_req;
					settle_next = 2'h0;
				end
			end
			SDADC_CONV: begin
				if (!conversion_start) begin
					state_next = SDADC_IDLE; // [RL1]
				end else if (mod_bit_valid) begin
					acc_next = acc_reg + {{(SDADC_ACC_W-1){1'b0}}, mod_bit}; // [RL13]
					cnt_next = cnt_reg + 11'h001;
					if (step) begin
						acc_next = '0;
						cnt_next = '0;
						res_next = acc_reg[15:0] + {15'h0000, mod_bit}; // [RL13]
						flag_next = 1'b1; // [RL15]
						if (nconv_reg != SDADC_START_MASK) begin
							nconv_next = nconv_reg + 3'h1;
						end
						if (settle_reg != 2'h0) begin
							settle_next = settle_reg - 2'h1; // [RL10]
						end
						if (pair_reg != input_control_reg.input_pair_select || gain_reg != gain_req) begin
							pair_next = input_control_reg.input_pair_select; // [RL9] [RL17]
							gain_next = gain_req; // [RL9] [RL17]
							settle_next = SDADC_SETTLE_CNT; // [RL10]
						end
						if ((input_control_reg.interrupt_delay_select != 2'h0
							|| nconv_reg >= SDADC_START_MASK - 3'h1)
							&& (settle_reg == 2'h0 || input_control_reg.interrupt_delay_select
							!= 2'h0)) begin
							irq_next = 1'b1; // [RL11] [RL10]
						end
						if (single_conversion_select) begin
							state_next = SDADC_IDLE; // [RL16]
							rearm_next = 1'b1; // [RL16]
						end
					end
				end
			end
			default: state_next = SDADC_IDLE;
		endcase
		case (sdadc_buf_e'(input_control_reg.input_buffer_speed)) // [RL12]
			SDADC_BUF_OFF: buf_next = 4'h1;
			SDADC_BUF_LOW: buf_next = 4'h2;
			SDADC_BUF_MED: buf_next = 4'h4;
			SDADC_BUF_HIGH: buf_next = 4'h8;
			default: buf_next = 4'h1;
		endcase
		pwr_next = (state_next == SDADC_CONV); // [RL1]
		busy_next = (state_next == SDADC_CONV);
		settling_next = (settle_next != 2'h0); // [RL10]
		rgen_next = internal_ref_enable; // [RL2] [RL3]
		rpin_next = ref_output_buffer_enable; // [RL4]
		ext_next = !internal_ref_enable && !ref_output_buffer_enable; // [RL5]
	end
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			assign dis_next[g] = pin_analog_enable[g]; // [RL8]
		end
	endgenerate
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= SDADC_IDLE;
			acc_reg <= '0;
			cnt_reg <= '0;
			pair_reg <= 3'h0;
			gain_reg <= 3'h0;
			settle_reg <= 2'h0;
			nconv_reg <= SDADC_CNT_RST;
			res_reg <= 16'h0000;
			flag_reg <= 1'b0;
			irq_reg <= 1'b0;
			buf_reg <= 4'h1;
			dis_reg <= '0;
			pwr_reg <= 1'b0;
			rgen_reg <= 1'b0;
			rpin_reg <= 1'b0;
			ext_reg <= 1'b0;
			rearm_reg <= 1'b0;
			busy_reg <= 1'b0;
			settling_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			acc_reg <= acc_next;
			cnt_reg <= cnt_next;
			pair_reg <= pair_next;
			gain_reg <= gain_next;
			settle_reg <= settle_next;
			nconv_reg <= nconv_next;
			res_reg <= res_next;
			flag_reg <= flag_next;
			irq_reg <= irq_next;
			buf_reg <= buf_next;
			dis_reg <= dis_next;
			pwr_reg <= pwr_next;
			rgen_reg <= rgen_next;
			rpin_reg <= rpin_next;
			ext_reg <= ext_next;
			rearm_reg <= rearm_next;
			busy_reg <= busy_next;
			settling_reg <= settling_next;
		end
	end
	assign conv_power_on = pwr_reg;
	assign ref_gen_on = rgen_reg;
	assign ref_pin_drive = rpin_reg;
	assign ext_ref_accept = ext_reg;
	assign active_pair = pair_reg;
	assign active_gain = gain_reg;
	assign buffer_enable = buf_reg;
	assign pin_digital_disable = dis_reg;
	assign conversion_result_reg = res_reg;
	assign conversion_done_flag = flag_reg;
	assign conversion_irq = irq_reg;
	assign result_settling = settling_reg;
	assign conversion_busy = busy_reg;
	chk_ref_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
		internal_ref_enable |=> ref_gen_on) else $error("reference not on"); // [RL3]
	chk_ref_stays: assert property (@(posedge clk_sys) disable iff (!rstn)
		(internal_ref_enable && !conversion_busy) |=> ref_gen_on) else $error("ref dropped"); // [RL2]
	chk_pin_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
		ref_output_buffer_enable |=> ref_pin_drive) else $error("ref pin not driven"); // [RL4]
	chk_ext_ref: assert property (@(posedge clk_sys) disable iff (!rstn)
		ext_ref_accept |-> !ref_gen_on && !ref_pin_drive) else $error("ext ref clash"); // [RL5]
	chk_power_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
		!conversion_start |=> !conv_power_on) else $error("power stays on"); // [RL1]
	chk_gain_range: assert property (@(posedge clk_sys) disable iff (!rstn)
		active_gain <= SDADC_GAIN_MAX) else $error("gain out of range"); // [RL7]
	chk_shadow_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(conversion_busy && !step && conversion_start) |=> $stable(active_pair))
		else $error("pair changed off step"); // [RL9]
	chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rstn)
		step |=> conversion_done_flag) else $error("done flag missing"); // [RL15]
	chk_pin_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		pin_analog_enable[0] |=> pin_digital_disable[0]) else $error("pin not gated"); // [RL8]
	chk_irq_mask: assert property (@(posedge clk_sys) disable iff (!rstn)
		(conversion_irq && input_control_reg.interrupt_delay_select == 2'h0
		&& $stable(input_control_reg.interrupt_delay_select))
		|-> $past(nconv_reg) >= 3'h3) else $error("irq before fourth"); // [RL11]
	chk_single_stop: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL16]
		(step && single_conversion_select) |=> !conversion_busy) else $error("single kept running");
	chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL15]
		((result_read || flag_clear) && !step) |=> !conversion_done_flag) else $error("flag kept");
	chk_settle_mark: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL10]
		(step && active_pair != input_control_reg.input_pair_select) |=> result_settling)
		else $error("settling not marked");
	chk_power_busy: assert property (@(posedge clk_sys) disable iff (!rstn) // [RL1]
		conversion_busy |-> conv_power_on) else $error("busy while powered down");
endmodule

// ---- rtl/sdadc_pkg.sv ----
// constants and types for the sigma-delta converter input control
// Contract
// [RL1] auto power-down when idle, up on start
// [RL2] power-down never switches reference off
// [RL3] reference on only while enable set
// [RL4] reference drives pin only when output enabled
// [RL5] external reference only when both cleared
// [RL6] eight input pairs, A5 A6 A7 internal
// [RL7] exactly six gain settings
// [RL8] analog enable disconnects pin digital logic
// [RL9] pair and gain change at decimation
// [RL10] three results after change possibly invalid
// [RL11] delay zero masks until fourth conversion
// [RL12] buffer speed select decodes four settings
// [RL13] one-bit stream averaged into result
// [RL14] comb decimation, ratio up to 1024
// [RL15] done flag set on result, cleared on read
// [RL16] single select: once or continuous
// [RL17] shadow pair and gain load at decimation
package sdadc_pkg;
	localparam int SDADC_RES_W = 16;
	localparam int SDADC_OSR_MAX = 1024;
	localparam int SDADC_ACC_W = 31;
	localparam logic [2:0] SDADC_PAIR_SUPPLY = 3'h5;
	localparam logic [2:0] SDADC_PAIR_TEMP = 3'h6;
	localparam logic [2:0] SDADC_PAIR_SHORT = 3'h7;
	localparam logic [2:0] SDADC_GAIN_MAX = 3'h5;
	localparam logic [1:0] SDADC_SETTLE_CNT = 2'h3;
	localparam logic [2:0] SDADC_START_MASK = 3'h4;
	localparam logic [2:0] SDADC_CNT_RST = 3'h0;
	typedef enum logic [1:0] {
		SDADC_BUF_OFF,
		SDADC_BUF_LOW,
		SDADC_BUF_MED,
		SDADC_BUF_HIGH
	} sdadc_buf_e;
	typedef struct packed {
		logic [2:0] input_pair_select;
		logic [2:0] amp_gain_select;
		logic [1:0] input_buffer_speed;
		logic [1:0] interrupt_delay_select;
	} sdadc_inctl_s;
	typedef enum {
		SDADC_IDLE,
		SDADC_CONV
	} sdadc_state_e;
endpackage

// ---- tb/sdadc_mod_model.sv ----
// modulator front end model: one-bit stream with a valid strobe
`timescale 1ns/1ns
module sdadc_mod_model (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ones,
	output logic mod_bit,
	output logic mod_bit_valid
);
	logic ph_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) ph_reg <= 1'b0;
		else ph_reg <= ~ph_reg;
	end
	assign mod_bit_valid = ph_reg;
	// with ones low the bit toggles every cycle, so stale values are not held; with ones high it stays 1
	assign mod_bit = ones | ~ph_reg;
endmodule

// ---- tb/sdadc_ctrl_tb.sv ----
// self-checking bench for the sigma-delta converter control
`timescale 1ns/1ns
module sdadc_ctrl_tb;
	import sdadc_pkg::*;
	logic clk_sys, rstn, internal_ref_enable, ref_output_buffer_enable, ones;
	logic conversion_start, single_conversion_select, result_read, flag_clear;
	sdadc_inctl_s input_control_reg;
	logic [7:0] pin_analog_enable, pin_digital_disable;
	logic [10:0] osr_select;
	logic mod_bit, mod_bit_valid, conv_power_on, ref_gen_on, ref_pin_drive, ext_ref_accept;
	logic conversion_done_flag, conversion_irq, result_settling, conversion_busy;
	logic [2:0] active_pair, active_gain;
	logic [3:0] buffer_enable;
	logic [15:0] conversion_result_reg;
	int num_errors = 0;
	int total_checks = 0;
	int irqs = 0;
	sdadc_ctrl #(.PINS(8)) dut_u (.clk_sys, .rstn, .internal_ref_enable,
		.ref_output_buffer_enable, .input_control_reg, .pin_analog_enable, .conversion_start,
		.single_conversion_select, .osr_select, .mod_bit, .mod_bit_valid, .result_read,
		.flag_clear, .conv_power_on, .ref_gen_on, .ref_pin_drive, .ext_ref_accept,
		.active_pair, .active_gain, .buffer_enable, .pin_digital_disable,
		.conversion_result_reg, .conversion_done_flag, .conversion_irq, .result_settling,
		.conversion_busy);
	sdadc_mod_model mod_u (.clk_sys, .rstn, .ones, .mod_bit, .mod_bit_valid);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (conversion_irq === 1'b1) irqs++;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	// wait for a result, compare it, then read it
	task automatic conv(input logic [15:0] exp);
		int i;
		for (i = 0; i < 3000 && conversion_done_flag !== 1'b1; i++) tick(1);
		chk(i < 3000, 1'b1);
		chk(conversion_result_reg, exp);
		result_read = 1'b1;
		tick(1);
		result_read = 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
	initial begin
		rstn = 1'b0;
		{internal_ref_enable, ref_output_buffer_enable, conversion_start} = 3'h0;
		{result_read, flag_clear, ones, single_conversion_select} = 4'h3;
		input_control_reg = '0;
		pin_analog_enable = 8'h00;
		osr_select = 11'h004;
		tick(5);
		rstn = 1'b1;
		tick(1);
		chk({buffer_enable, conv_power_on, conversion_done_flag}, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			{internal_ref_enable, ref_output_buffer_enable} = k[1:0];
			input_control_reg.input_buffer_speed = k[1:0];
			tick(2);
			chk({ref_gen_on, ref_pin_drive, ext_ref_accept}, {k[1], k[0], k == 0});
			chk(buffer_enable, 16'h1 << k);
		end
		pin_analog_enable = 8'hA5;
		tick(2);
		chk(pin_digital_disable, 8'hA5);
		internal_ref_enable = 1'b1;
		input_control_reg = '{3'h7, 3'h7, 2'h0, 2'h1};
		conversion_start = 1'b1;
		tick(2);
		chk({conv_power_on, active_pair, active_gain}, {1'b1, SDADC_PAIR_SHORT, SDADC_GAIN_MAX});
		conv(16'h0004);
		chk(conversion_done_flag, 1'b0);
		tick(2);
		chk({conversion_busy, conv_power_on, ref_gen_on}, 3'h1);
		conversion_start = 1'b0;
		ones = 1'b0;
		single_conversion_select = 1'b0;
		input_control_reg = '{3'h2, 3'h1, 2'h0, 2'h0};
		tick(1);
		irqs = 0;
		conversion_start = 1'b1;
		repeat (6) conv(16'h0000);
		tick(2);
		chk(irqs, 3);
		input_control_reg.input_pair_select = 3'h3;
		tick(1);
		chk(active_pair, 3'h2);
		conv(16'h0000);
		chk({active_pair, result_settling}, {3'h3, 1'b1});
		conversion_start = 1'b0;
		tick(3);
		chk({conversion_busy, conv_power_on}, 2'h0);
		osr_select = 11'h000;
		ones = 1'b1;
		single_conversion_select = 1'b1;
		conversion_start = 1'b1;
		conv(16'h0400);
		tick(2);
		chk(conversion_busy, 1'b0);
		test_done();
	end
endmodule
